// File: rtl/caption_route_mode_select.v
// Caption routing, bridging and monitor selection for a two-channel caption card.
// Notes on behaviour
// [RQ1] Routing selector groups: 0-2, 3-7, 8-9.
// [RQ2] Bridge selector picks direction and fields.
// [RQ3] Insert-only: 0 split, 1 serial, 2 ethernet.
// [RQ4] Channel A odd outputs, B even outputs.
// [RQ5] Monitor outputs burn in output captions.
// [RQ6] Locked channel inserts received data at once.
// [RQ7] Extraction leaves pass-through captions untouched.
// [RQ8] Bridging extracts source, inserts into destination.
// [RQ9] Bridge source output keeps its captions.
// [RQ10] Channels run independently, no mutual timing; a shared host word is taken only when both channels are ready.
// [RQ11] Extract and insert on a channel together.
// [RQ12] Extract only incoming captions, never inserted ones.
// [RQ13] Value 8 extracts A, 9 extracts B.
// [RQ14] Bridge destination rate must not be slower.
// [RQ15] Undefined routing codes route nothing.
`timescale 1ns/100ps
`include "caption_route_consts.vh"
module caption_route_mode_select #(
    parameter DW = 8
) (
    input  wire          i_clk,
    input  wire          i_rst_n,
    input  wire [3:0]    i_routing_selector,
    input  wire [3:0]    i_bridge_selector,
    input  wire          i_lock_a,
    input  wire          i_lock_b,
    input  wire          i_field2_a,
    input  wire          i_field2_b,
    input  wire [DW-1:0] i_in_cc_a,
    input  wire          i_in_cc_valid_a,
    input  wire [DW-1:0] i_in_cc_b,
    input  wire          i_in_cc_valid_b,
    input  wire [DW-1:0] i_serial_rx_data,
    input  wire          i_serial_rx_valid,
    output reg           o_serial_rx_ready,
    input  wire [DW-1:0] i_eth_rx_data,
    input  wire          i_eth_rx_valid,
    output reg           o_eth_rx_ready,
    input  wire          i_ins_ready_a,
    input  wire          i_ins_ready_b,
    output reg  [DW-1:0] o_ins_data_a,
    output reg           o_ins_valid_a,
    output reg  [DW-1:0] o_ins_data_b,
    output reg           o_ins_valid_b,
    output reg  [DW-1:0] o_serial_tx_data,
    output reg           o_serial_tx_valid,
    output reg  [DW-1:0] o_eth_tx_data,
    output reg           o_eth_tx_valid,
    output reg           o_out1_src_b,
    output reg           o_out2_src_b,
    output reg           o_mon3_src_b,
    output reg           o_mon4_src_b,
    output reg  [1:0]    o_mode
);
    reg        rst_s1_r;
    reg        rst_n_r;
    reg  [1:0] mode_nxt;
    reg        ins_ser_a;
    reg        ins_eth_a;
    reg        ins_ser_b;
    reg        ins_eth_b;
    reg        ext_a_ser;
    reg        ext_a_eth;
    reg        ext_b_ser;
    reg        ext_b_eth;
    reg        br_ab;
    reg        br_ba;
    reg        br_f1;
    reg        br_f2;

    // Reset is released through two flops so every register leaves reset on the same edge.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // Routing decode; codes outside 0..9 leave every port idle.
    always @* begin
        mode_nxt  = `MODE_NONE;
        ins_ser_a = 1'b0;
        ins_eth_a = 1'b0;
        ins_ser_b = 1'b0;
        ins_eth_b = 1'b0;
        ext_a_ser = 1'b0;
        ext_a_eth = 1'b0;
        ext_b_ser = 1'b0;
        ext_b_eth = 1'b0;
        case (i_routing_selector)
            4'h0: begin
                mode_nxt  = `MODE_INS; // RQ1
                ins_ser_a = 1'b1; // RQ3
                ins_eth_b = 1'b1;
            end
            4'h1: begin
                mode_nxt  = `MODE_INS;
                ins_ser_a = 1'b1; // RQ3
                ins_ser_b = 1'b1;
            end
            4'h2: begin
                mode_nxt  = `MODE_INS;
                ins_eth_a = 1'b1; // RQ3
                ins_eth_b = 1'b1;
            end
            4'h3: begin
                mode_nxt  = `MODE_BOTH; // RQ1
                ins_ser_a = 1'b1; // RQ11
                ins_eth_b = 1'b1;
                ext_a_ser = 1'b1;
                ext_b_eth = 1'b1;
            end
            4'h4, 4'h7: begin
                mode_nxt  = `MODE_BOTH;
                ins_ser_a = (i_routing_selector == 4'h4);
                ins_ser_b = (i_routing_selector == 4'h4);
                ins_eth_a = (i_routing_selector == 4'h7);
                ins_eth_b = (i_routing_selector == 4'h7);
                ext_a_ser = 1'b1;
                ext_a_eth = 1'b1;
            end
            4'h5, 4'h6: begin
                mode_nxt  = `MODE_BOTH;
                ins_eth_a = (i_routing_selector == 4'h5);
                ins_eth_b = (i_routing_selector == 4'h5);
                ins_ser_a = (i_routing_selector == 4'h6);
                ins_ser_b = (i_routing_selector == 4'h6);
                ext_b_ser = 1'b1;
                ext_b_eth = 1'b1;
            end
            `ROUTE_EXT_A: begin
                mode_nxt  = `MODE_EXT; // RQ1
                ext_a_ser = 1'b1; // RQ13
                ext_a_eth = 1'b1;
            end
            `ROUTE_EXT_B: begin
                mode_nxt  = `MODE_EXT;
                ext_b_ser = 1'b1; // RQ13
                ext_b_eth = 1'b1;
            end
            default: begin
                mode_nxt  = `MODE_NONE; // RQ15
            end
        endcase
    end

    // Bridge decode; 0 and 7..F leave both channels unbridged.
    always @* begin
        br_ab = 1'b0;
        br_ba = 1'b0;
        br_f1 = 1'b0;
        br_f2 = 1'b0;
        case (i_bridge_selector)
            `BRIDGE_AB_BOTH, `BRIDGE_BA_BOTH: begin
                br_ab = (i_bridge_selector == `BRIDGE_AB_BOTH); // RQ2
                br_ba = (i_bridge_selector == `BRIDGE_BA_BOTH);
                br_f1 = 1'b1;
                br_f2 = 1'b1;
            end
            `BRIDGE_AB_F1, `BRIDGE_BA_F1: begin
                br_ab = (i_bridge_selector == `BRIDGE_AB_F1); // RQ2
                br_ba = (i_bridge_selector == `BRIDGE_BA_F1);
                br_f1 = 1'b1;
            end
            `BRIDGE_AB_F2, `BRIDGE_BA_F2: begin
                br_ab = (i_bridge_selector == `BRIDGE_AB_F2); // RQ2
                br_ba = (i_bridge_selector == `BRIDGE_BA_F2);
                br_f2 = 1'b1;
            end
            default: begin
                br_ab = 1'b0;
            end
        endcase
    end

    // A word from the source channel is bridged only in a selected field.
    wire bridge_a_word = br_ab && i_in_cc_valid_a && (i_field2_a ? br_f2 : br_f1); // RQ8
    wire bridge_b_word = br_ba && i_in_cc_valid_b && (i_field2_b ? br_f2 : br_f1); // RQ8

    // Insertion sources per channel. Bridge words win over host words; a host port feeding only that channel is stalled, a shared one feeds the other channel alone.
    wire          ser_to_a = ins_ser_a && !bridge_b_word;
    wire          eth_to_a = ins_eth_a && !bridge_b_word;
    wire          ser_to_b = ins_ser_b && !bridge_a_word;
    wire          eth_to_b = ins_eth_b && !bridge_a_word;
    wire [DW-1:0] feed_a   = bridge_b_word ? i_in_cc_b : (ser_to_a ? i_serial_rx_data : i_eth_rx_data);
    wire [DW-1:0] feed_b   = bridge_a_word ? i_in_cc_a : (ser_to_b ? i_serial_rx_data : i_eth_rx_data);
    wire          feed_va  = i_lock_a && (bridge_b_word || (ser_to_a && i_serial_rx_valid) ||
                             (eth_to_a && i_eth_rx_valid)); // RQ6
    wire          feed_vb  = i_lock_b && (bridge_a_word || (ser_to_b && i_serial_rx_valid) ||
                             (eth_to_b && i_eth_rx_valid)); // RQ6
    wire          rdy_a;
    wire          rdy_b;
    wire [DW-1:0] buf_da;
    wire [DW-1:0] buf_db;
    wire          buf_va;
    wire          buf_vb;
    // A host word shared by both channels is taken only when both can accept it.
    // The host still shows a taken word until it sees ready, so that cycle must not take it again.
    wire          take_ser = i_serial_rx_valid && !o_serial_rx_ready && ((ser_to_a && ser_to_b) ?
                             (rdy_a && rdy_b && i_lock_a && i_lock_b) :
                             ((ser_to_a && rdy_a && i_lock_a) || (ser_to_b && rdy_b && i_lock_b)));
    wire          take_eth = i_eth_rx_valid && !o_eth_rx_ready && ((eth_to_a && eth_to_b) ?
                             (rdy_a && rdy_b && i_lock_a && i_lock_b) :
                             ((eth_to_a && rdy_a && i_lock_a) || (eth_to_b && rdy_b && i_lock_b)));
    wire          push_a   = feed_va && (bridge_b_word || (ser_to_a ? take_ser : take_eth));
    wire          push_b   = feed_vb && (bridge_a_word || (ser_to_b ? take_ser : take_eth));
    wire          out_ack_a = !o_ins_valid_a || i_ins_ready_a;
    wire          out_ack_b = !o_ins_valid_b || i_ins_ready_b;

    // Per-channel buffers, each on its own stream handshake.
    caption_skid_buffer #(.W(DW)) u_buf_a (
        .i_clk   (i_clk),
        .i_rst_n (rst_n_r),
        .i_data  (feed_a),
        .i_valid (push_a),
        .o_ready (rdy_a),
        .o_data  (buf_da),
        .o_valid (buf_va),
        .i_ready (out_ack_a)
    ); // RQ10
    caption_skid_buffer #(.W(DW)) u_buf_b (
        .i_clk   (i_clk),
        .i_rst_n (rst_n_r),
        .i_data  (feed_b),
        .i_valid (push_b),
        .o_ready (rdy_b),
        .o_data  (buf_db),
        .o_valid (buf_vb),
        .i_ready (out_ack_b)
    ); // RQ10

    // Output registers. Extraction taps only incoming words, so inserted captions never echo back.
    always @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            o_mode            <= `MODE_NONE;
            o_ins_data_a      <= {DW{1'b0}};
            o_ins_valid_a     <= 1'b0;
            o_ins_data_b      <= {DW{1'b0}};
            o_ins_valid_b     <= 1'b0;
            o_serial_tx_data  <= {DW{1'b0}};
            o_serial_tx_valid <= 1'b0;
            o_eth_tx_data     <= {DW{1'b0}};
            o_eth_tx_valid    <= 1'b0;
            o_serial_rx_ready <= 1'b0;
            o_eth_rx_ready    <= 1'b0;
            o_out1_src_b      <= 1'b0;
            o_out2_src_b      <= 1'b1;
            o_mon3_src_b      <= 1'b0;
            o_mon4_src_b      <= 1'b1;
        end else begin
            o_mode <= mode_nxt; // RQ1
            if (out_ack_a) begin
                o_ins_valid_a <= buf_va; // RQ6
                o_ins_data_a  <= buf_da;
            end
            if (out_ack_b) begin
                o_ins_valid_b <= buf_vb;
                o_ins_data_b  <= buf_db;
            end
            // Serial gets A when both extract to it; B's word is then dropped (host link is text only).
            o_serial_tx_valid <= (ext_a_ser && i_in_cc_valid_a) || (ext_b_ser && i_in_cc_valid_b); // RQ12
            o_serial_tx_data  <= (ext_a_ser && i_in_cc_valid_a) ? i_in_cc_a : i_in_cc_b; // RQ7
            o_eth_tx_valid    <= (ext_a_eth && i_in_cc_valid_a) || (ext_b_eth && i_in_cc_valid_b); // RQ12
            o_eth_tx_data     <= (ext_a_eth && i_in_cc_valid_a) ? i_in_cc_a : i_in_cc_b; // RQ7
            o_serial_rx_ready <= take_ser;
            o_eth_rx_ready    <= take_eth;
            // Fixed video routing; bridging never strips the source output's captions.
            o_out1_src_b <= 1'b0; // RQ4
            o_out2_src_b <= 1'b1; // RQ4
            o_mon3_src_b <= o_out1_src_b; // RQ5
            o_mon4_src_b <= o_out2_src_b; // RQ9
        end
    end
endmodule

// File: rtl/caption_route_consts.vh
// Constants for the caption routing and mode selection block.
`ifndef CAPTION_ROUTE_CONSTS_VH
`define CAPTION_ROUTE_CONSTS_VH
`define SEL_W              4
`define ROUTE_INS_LAST     4'h2
`define ROUTE_BOTH_FIRST   4'h3
`define ROUTE_BOTH_LAST    4'h7
`define ROUTE_EXT_A        4'h8
`define ROUTE_EXT_B        4'h9
`define ROUTE_INS_SPLIT    4'h0
`define ROUTE_INS_SERIAL   4'h1
`define ROUTE_INS_ETH      4'h2
`define BRIDGE_AB_BOTH     4'h1
`define BRIDGE_BA_BOTH     4'h2
`define BRIDGE_AB_F1       4'h3
`define BRIDGE_BA_F1       4'h4
`define BRIDGE_AB_F2       4'h5
`define BRIDGE_BA_F2       4'h6
`define MODE_NONE          2'h0
`define MODE_INS           2'h1
`define MODE_BOTH          2'h2
`define MODE_EXT           2'h3
`define BUF_DEPTH          2
`endif

// File: rtl/caption_skid_buffer.v
// Two-entry valid/ready buffer used in each caption insertion path.
`timescale 1ns/100ps
module caption_skid_buffer #(
    parameter W = 8
) (
    input  wire         i_clk,
    input  wire         i_rst_n,
    input  wire [W-1:0] i_data,
    input  wire         i_valid,
    output wire         o_ready,
    output wire [W-1:0] o_data,
    output wire         o_valid,
    input  wire         i_ready
);
    reg [W-1:0] mem_r [0:1];
    reg         wp_r;
    reg         rp_r;
    reg [1:0]   cnt_r;
    wire        push = i_valid && (cnt_r != 2'd2);
    wire        pop  = i_ready && (cnt_r != 2'd0);

    assign o_ready = (cnt_r != 2'd2);
    assign o_valid = (cnt_r != 2'd0);
    assign o_data  = mem_r[rp_r];

    // Pointers and fill count; a full buffer lowers o_ready, and a word pushed while it is full is dropped.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wp_r  <= 1'b0;
            rp_r  <= 1'b0;
            cnt_r <= 2'd0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
        end
    end

    // Storage has no reset; empty entries are never presented.
    always @(posedge i_clk) begin
        if (push) begin
            mem_r[wp_r] <= i_data;
        end
    end
endmodule

// File: testbench/caption_route_asserts.sv
// Port-level checks for the caption routing block.
`timescale 1ns/100ps
`include "caption_route_consts.vh"
module caption_route_asserts #(
    parameter DW = 8
) (
    input wire          i_clk,
    input wire          i_rst_n,
    input wire [3:0]    i_routing_selector,
    input wire          i_lock_a,
    input wire          i_lock_b,
    input wire [DW-1:0] i_in_cc_a,
    input wire          i_in_cc_valid_a,
    input wire [DW-1:0] i_in_cc_b,
    input wire          i_in_cc_valid_b,
    input wire          o_serial_rx_ready,
    input wire          o_eth_rx_ready,
    input wire          i_ins_ready_a,
    input wire [DW-1:0] o_ins_data_a,
    input wire          o_ins_valid_a,
    input wire [DW-1:0] o_serial_tx_data,
    input wire          o_serial_tx_valid,
    input wire [DW-1:0] o_eth_tx_data,
    input wire          o_eth_tx_valid,
    input wire [1:0]    o_mode
);
    reg  [1:0] up_r;
    reg  [3:0] sel1_r;
    reg  [3:0] sel2_r;
    wire [3:0] sel = i_routing_selector;
    wire       held = (up_r == 2'h3) && (sel == sel1_r) && (sel1_r == sel2_r);
    wire [1:0] mode_exp = (sel <= 4'h2) ? `MODE_INS : (sel <= 4'h7) ? `MODE_BOTH :
                          (sel <= 4'h9) ? `MODE_EXT : `MODE_NONE;
    // Mode trails the selector, so checks wait until the code has held still past the reset sync.
    always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_r   <= 2'h0;
            sel1_r <= 4'h0;
            sel2_r <= 4'h0;
        end else begin
            up_r   <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
            sel1_r <= sel;
            sel2_r <= sel1_r;
        end
    end
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);
    mode_map_a: assert property (held |-> o_mode == mode_exp)
        else $error("mode differs from selector");
    no_route_a: assert property (held && sel > 4'h9 |-> o_mode == `MODE_NONE && !o_serial_tx_valid)
        else $error("undefined code routes text");
    insert_quiet_a: assert property (held && sel <= 4'h2 |-> !o_serial_tx_valid && !o_eth_tx_valid)
        else $error("text sent in insert-only mode");
    extract_a_a: assert property (held && sel == 4'h8 && i_in_cc_valid_a |=>
        o_serial_tx_valid && o_eth_tx_valid && o_eth_tx_data == $past(i_in_cc_a)) else $error("channel A text lost");
    extract_b_a: assert property (held && sel == 4'h9 && i_in_cc_valid_b |=>
        o_serial_tx_valid && o_eth_tx_valid && o_serial_tx_data == $past(i_in_cc_b)) else $error("channel B text lost");
    tx_cause_a: assert property (o_serial_tx_valid || o_eth_tx_valid |->
        $past(i_in_cc_valid_a || i_in_cc_valid_b)) else $error("text without incoming word");
    host_route_a: assert property (held |-> !(sel == 4'h2 && o_serial_rx_ready) &&
        !(sel == 4'h1 && o_eth_rx_ready)) else $error("unrouted host port taken");
    lock_gate_a: assert property (o_serial_rx_ready || o_eth_rx_ready |-> $past(i_lock_a || i_lock_b))
        else $error("host word taken while unlocked");
    ins_hold_a: assert property (o_ins_valid_a && !i_ins_ready_a |=> o_ins_valid_a && $stable(o_ins_data_a))
        else $error("stalled insert word dropped");
    cover property (held && sel == 4'h8 && i_in_cc_valid_a);
    cover property (o_ins_valid_a && !i_ins_ready_a);
    cover property (o_serial_rx_ready && o_eth_rx_ready);
endmodule
bind caption_route_mode_select caption_route_asserts #(.DW(DW)) caption_route_asserts_inst (.i_clk(i_clk),
    .i_rst_n(i_rst_n), .i_routing_selector(i_routing_selector), .i_lock_a(i_lock_a), .i_lock_b(i_lock_b),
    .i_in_cc_a(i_in_cc_a), .i_in_cc_valid_a(i_in_cc_valid_a), .i_in_cc_b(i_in_cc_b), .i_in_cc_valid_b(i_in_cc_valid_b),
    .o_serial_rx_ready(o_serial_rx_ready), .o_eth_rx_ready(o_eth_rx_ready), .i_ins_ready_a(i_ins_ready_a),
    .o_ins_data_a(o_ins_data_a), .o_ins_valid_a(o_ins_valid_a), .o_serial_tx_data(o_serial_tx_data),
    .o_serial_tx_valid(o_serial_tx_valid), .o_eth_tx_data(o_eth_tx_data), .o_eth_tx_valid(o_eth_tx_valid),
    .o_mode(o_mode));

// File: testbench/caption_far_side.sv
// Host senders and channel inserters on the far side of the routing block.
`timescale 1ns/100ps
module caption_far_side (
    input  wire       i_clk,
    input  wire       i_req_ser,
    input  wire       i_req_eth,
    input  wire [7:0] i_word,
    input  wire       i_stall_en,
    input  wire [1:0] i_stall,
    input  wire       i_serial_rx_ready,
    input  wire       i_eth_rx_ready,
    output reg  [7:0] o_serial_rx_data = 8'h00,
    output reg        o_serial_rx_valid = 1'b0,
    output reg  [7:0] o_eth_rx_data = 8'h00,
    output reg        o_eth_rx_valid = 1'b0,
    output wire       o_ins_ready_a,
    output wire       o_ins_ready_b
);
    // Inserters stall at random so the block's buffers must hold words back.
    assign o_ins_ready_a = !(i_stall_en && i_stall[0]);
    assign o_ins_ready_b = !(i_stall_en && i_stall[1]);
    // A word is held until ready is seen; an idle data line toggles so stale data never looks valid.
    always @(posedge i_clk) begin
        if (!o_serial_rx_valid && i_req_ser) begin
            o_serial_rx_valid <= 1'b1;
            o_serial_rx_data  <= i_word;
        end else if (!o_serial_rx_valid || i_serial_rx_ready) begin
            o_serial_rx_valid <= 1'b0;
            o_serial_rx_data  <= ~o_serial_rx_data;
        end
        if (!o_eth_rx_valid && i_req_eth) begin
            o_eth_rx_valid <= 1'b1;
            o_eth_rx_data  <= ~i_word;
        end else if (!o_eth_rx_valid || i_eth_rx_ready) begin
            o_eth_rx_valid <= 1'b0;
            o_eth_rx_data  <= ~o_eth_rx_data;
        end
    end
endmodule

// File: testbench/tb.sv
// Self-checking testbench for the caption routing block.
`timescale 1ns/100ps
`include "caption_route_consts.vh"
module tb;
    reg        i_clk = 1'b0;
    reg        i_rst_n = 1'b0;
    reg  [3:0] rsel = 4'h0, bsel = 4'h0;
    reg  [7:0] cc_a = 8'h00, cc_b = 8'h00, word = 8'h00, w;
    reg        f2_a = 1'b0, f2_b = 1'b0, ccv_a = 1'b0, ccv_b = 1'b0, req_s = 1'b0, req_e = 1'b0, stall_en = 1'b0;
    reg        lock_a = 1'b1, lock_b = 1'b1;
    reg  [1:0] stall = 2'h0;
    wire [7:0] srx_d, erx_d, ins_a, ins_b, stx_d, etx_d;
    wire       srx_v, erx_v, srx_r, erx_r, rdy_a, rdy_b, insv_a, insv_b, stx_v, etx_v, o1, o2, m3, m4;
    wire [1:0] mode;
    integer    seed = 6098, errors = 0, checked = 0, i, j;
    reg  [7:0] qa[$], qb[$];
    always #2 i_clk = ~i_clk;
    caption_route_mode_select #(.DW(8)) caption_route_mode_select_inst (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_routing_selector(rsel), .i_bridge_selector(bsel), .i_lock_a(lock_a), .i_lock_b(lock_b), .i_field2_a(f2_a),
        .i_field2_b(f2_b), .i_in_cc_a(cc_a), .i_in_cc_valid_a(ccv_a), .i_in_cc_b(cc_b), .i_in_cc_valid_b(ccv_b),
        .i_serial_rx_data(srx_d), .i_serial_rx_valid(srx_v), .o_serial_rx_ready(srx_r), .i_eth_rx_data(erx_d),
        .i_eth_rx_valid(erx_v), .o_eth_rx_ready(erx_r), .i_ins_ready_a(rdy_a), .i_ins_ready_b(rdy_b),
        .o_ins_data_a(ins_a), .o_ins_valid_a(insv_a), .o_ins_data_b(ins_b), .o_ins_valid_b(insv_b),
        .o_serial_tx_data(stx_d), .o_serial_tx_valid(stx_v), .o_eth_tx_data(etx_d), .o_eth_tx_valid(etx_v),
        .o_out1_src_b(o1), .o_out2_src_b(o2), .o_mon3_src_b(m3), .o_mon4_src_b(m4), .o_mode(mode));
    caption_far_side caption_far_side_inst (.i_clk(i_clk), .i_req_ser(req_s), .i_req_eth(req_e), .i_word(word),
        .i_stall_en(stall_en), .i_stall(stall), .i_serial_rx_ready(srx_r), .i_eth_rx_ready(erx_r),
        .o_serial_rx_data(srx_d), .o_serial_rx_valid(srx_v), .o_eth_rx_data(erx_d), .o_eth_rx_valid(erx_v),
        .o_ins_ready_a(rdy_a), .o_ins_ready_b(rdy_b));
    task cmp(input [7:0] got, input [7:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                errors = errors + 1;
                $display("[FAIL] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task close_out;
        begin
            $display("errors %0d checked %0d", errors, checked);
            if (errors == 0 && checked > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    function [1:0] exp_mode(input [3:0] s);
        exp_mode = (s <= 4'h2) ? `MODE_INS : (s <= 4'h7) ? `MODE_BOTH : (s <= 4'h9) ? `MODE_EXT : `MODE_NONE;
    endfunction
    // Returns which ports carry text from channel ch, serial in the upper bit.
    function [1:0] exp_tx(input [3:0] s, input ch);
        case (s)
            4'h3: exp_tx = ch ? 2'b01 : 2'b10;
            4'h4, 4'h7, 4'h8: exp_tx = ch ? 2'b00 : 2'b11;
            4'h5, 4'h6, 4'h9: exp_tx = ch ? 2'b11 : 2'b00;
            default: exp_tx = 2'b00;
        endcase
    endfunction
    function exp_br(input [3:0] b, input src, input f2);
        exp_br = b >= 4'h1 && b <= 4'h6 && src == !b[0] && (b <= 4'h2 || (b <= 4'h4) == !f2);
    endfunction
    // Insert routes per code: serial to A, serial to B, ethernet to A, ethernet to B.
    function [3:0] exp_ins(input [3:0] s);
        case (s)
            4'h0, 4'h3: exp_ins = 4'b1001;
            4'h1, 4'h4, 4'h6: exp_ins = 4'b1100;
            4'h2, 4'h5, 4'h7: exp_ins = 4'b0011;
            default: exp_ins = 4'b0000;
        endcase
    endfunction
    wire [3:0] route = exp_ins(rsel);
    // Random stalls and host words change just after each edge.
    always @(posedge i_clk) begin
        stall <= $random(seed);
        word  <= $random(seed);
    end
    // Each acknowledged host word is expected on the routed inserters, in order.
    always @(posedge i_clk) begin
        if (srx_r && route[3]) qa.push_back(srx_d);
        if (srx_r && route[2]) qb.push_back(srx_d);
        if (erx_r && route[1]) qa.push_back(erx_d);
        if (erx_r && route[0]) qb.push_back(erx_d);
        if (insv_a && rdy_a) cmp(ins_a, qa.size() ? qa.pop_front() : 8'hxx);
        if (insv_b && rdy_b) cmp(ins_b, qb.size() ? qb.pop_front() : 8'hxx);
    end
    // A hang counts as a mismatch; the run needs about sixteen hundred cycles.
    initial begin
        #40000;
        errors = errors + 1;
        close_out;
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_clk);
        for (i = 0; i < 16; i = i + 1) begin
            rsel <= i[3:0];
            repeat (3) @(posedge i_clk);
            #1 cmp({6'h00, mode}, {6'h00, exp_mode(i[3:0])});
            cmp({4'h0, o1, o2, m3, m4}, 8'h05);
            for (j = 0; j < 2; j = j + 1) begin
                @(posedge i_clk);
                cc_a  <= $random(seed);
                cc_b  <= $random(seed);
                ccv_a <= (j == 0);
                ccv_b <= (j == 1);
                @(posedge i_clk);
                ccv_a <= 1'b0;
                ccv_b <= 1'b0;
                #1 cmp({6'h00, stx_v, etx_v}, {6'h00, exp_tx(i[3:0], j[0])});
                if (stx_v === 1'b1) cmp(stx_d, j ? cc_b : cc_a);
                if (etx_v === 1'b1) cmp(etx_d, j ? cc_b : cc_a);
            end
        end
        // Host traffic on routed ports only, with the inserters stalling.
        stall_en <= 1'b1;
        for (i = 0; i < 8; i = i + 1) begin
            rsel <= i[3:0];
            repeat (3) @(posedge i_clk);
            repeat (60) begin
                @(posedge i_clk);
                req_s <= $random(seed) & (route[3] | route[2]);
                req_e <= $random(seed) & (route[1] | route[0]);
            end
            @(posedge i_clk);
            req_s <= 1'b0;
            req_e <= 1'b0;
            repeat (30) @(posedge i_clk);
        end
        // Unlocked channels take no host word; the held word goes in once lock returns.
        lock_a <= 1'b0;
        lock_b <= 1'b0;
        rsel   <= 4'h1;
        req_s  <= 1'b1;
        repeat (20) begin
            @(posedge i_clk);
            cmp({7'h00, srx_r}, 8'h00);
        end
        req_s  <= 1'b0;
        lock_a <= 1'b1;
        lock_b <= 1'b1;
        repeat (10) @(posedge i_clk);
        stall_en <= 1'b0;
        rsel     <= 4'h0;
        // Words are spaced widely so a destination never runs slower than its source.
        for (i = 0; i < 16; i = i + 1) begin
            bsel <= i[3:0];
            repeat (3) @(posedge i_clk);
            for (j = 0; j < 4; j = j + 1) begin
                @(posedge i_clk);
                w = $random(seed);
                cc_a  <= w;
                cc_b  <= w;
                f2_a  <= j[1];
                f2_b  <= j[1];
                ccv_a <= !j[0];
                ccv_b <= j[0];
                if (exp_br(i[3:0], j[0], j[1]) && j[0]) qa.push_back(w);
                if (exp_br(i[3:0], j[0], j[1]) && !j[0]) qb.push_back(w);
                @(posedge i_clk);
                ccv_a <= 1'b0;
                ccv_b <= 1'b0;
                repeat (8) @(posedge i_clk);
            end
        end
        repeat (20) @(posedge i_clk);
        cmp(8'(qa.size() + qb.size()), 8'h00);
        close_out;
    end
endmodule
